// ---- include/ibmc_pkg.sv ----
// constants and state type shared by the two-wire bus-mode controller
package ibmc_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_LOW_NS = 4700;
  localparam int T_HIGH_NS = 4000;
  localparam int LOW_CYC = (T_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HIGH_CYC = (T_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 12;
  localparam logic [1:0] FUNC_PORT = 2'h0;
  localparam logic [1:0] FUNC_BUS = 2'h2;
  localparam logic [1:0] KEY_FIRST = 2'h2;
  localparam logic [1:0] KEY_SECOND = 2'h1;
  localparam logic [3:0] CMD_START = 4'hF;
  localparam logic [3:0] CMD_STOP = 4'hD;
  localparam logic [7:0] GEN_CALL = 8'h00;
  localparam logic [2:0] BC_RESET = 3'h0;
  localparam logic [3:0] FULL_WORD = 4'h8;
  localparam logic [6:0] OWN_ID_RESET = 7'h00;
  localparam logic PEND_RESET = 1'h1;
  localparam logic SOFT_DONE_RESET = 1'h1;
  typedef enum logic [3:0] {
    S_IDLE, S_SLV, S_START, S_LOW, S_HIGH, S_HOLD, S_STOPA, S_STOPB, S_STOPC
  } ibmc_state_e;
endpackage

// ---- hdl/ibmc_sync.sv ----
// two-flop synchroniser for the bus pin levels
`timescale 1ns/100ps
`default_nettype none
module ibmc_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clock, // system clock
  input wire logic nrst, // synchronous reset, active low
  input wire logic [WIDTH-1:0] din, // levels from the pins
  output logic [WIDTH-1:0] dout // levels in the clock domain
);
  logic [WIDTH-1:0] meta_reg;

  // idle bus is high, so both stages reset high
  always_ff @(posedge clock) begin
    if (!nrst) begin
      meta_reg <= {WIDTH{1'b1}};
      dout <= {WIDTH{1'b1}};
    end else begin
      meta_reg <= din;
      dout <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// ---- hdl/ibmc_cond_det.sv ----
// edge and start/stop condition detector on synchronised bus levels
`timescale 1ns/100ps
`default_nettype none
module ibmc_cond_det (
  input wire logic clock, // system clock
  input wire logic nrst, // synchronous reset, active low
  input wire logic scl, // synchronised clock line
  input wire logic sda, // synchronised data line
  output logic sclRise, // one-cycle pulse on clock rise
  output logic sclFall, // one-cycle pulse on clock fall
  output logic startDet, // one-cycle pulse on start condition
  output logic stopDet // one-cycle pulse on stop condition
);
  logic sclPrev_reg;
  logic sdaPrev_reg;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      sclPrev_reg <= 1'b1;
      sdaPrev_reg <= 1'b1;
      sclRise <= 1'b0;
      sclFall <= 1'b0;
      startDet <= 1'b0;
      stopDet <= 1'b0;
    end else begin
      sclPrev_reg <= scl;
      sdaPrev_reg <= sda;
      sclRise <= scl && !sclPrev_reg;
      sclFall <= !scl && sclPrev_reg;
      startDet <= scl && sclPrev_reg && sdaPrev_reg && !sda;
      stopDet <= scl && sclPrev_reg && !sdaPrev_reg && sda;
    end
  end
endmodule
`default_nettype wire

// ---- hdl/ibmc_ctrl.sv ----
// two-wire bus-mode controller: addressing, start/stop, pending hold, arbitration
`timescale 1ns/100ps
`default_nettype none
module ibmc_ctrl #(
  parameter int LOW_CYC = ibmc_pkg::LOW_CYC,
  parameter int HIGH_CYC = ibmc_pkg::HIGH_CYC
) (
  input wire logic clock, // system clock, 100 MHz
  input wire logic nrst, // synchronous reset, active low
  input wire logic sclIn, // clock line level
  output logic sclOut, // clock line drive value
  output logic sclOe, // clock line pulled low while high
  input wire logic sdaIn, // data line level
  output logic sdaOut, // data line drive value
  output logic sdaOe, // data line pulled low while high
  input wire logic cr1Write, // strobe for control_one fields
  input wire logic ackModeIn, // acknowledge mode to write
  input wire logic [2:0] bitCountIn, // bits per word to write, 0 = 8
  input wire logic cr2Write, // strobe for control_two fields
  input wire logic masterIn, // master select to write
  input wire logic dirIn, // transmit direction to write
  input wire logic busyIn, // busy bit to write
  input wire logic pendIn, // pending bit to write
  input wire logic [1:0] keyIn, // soft_init_key to write
  input wire logic [1:0] funcSelIn, // interface_function_sel to write
  input wire logic idWrite, // strobe for own_id_register
  input wire logic [6:0] ownIdIn, // own slave id to write
  input wire logic freeFmtIn, // free format select to write
  input wire logic bufWrite, // shift_buffer write strobe
  input wire logic [7:0] bufWrData, // shift_buffer write data
  input wire logic bufRead, // shift_buffer read strobe
  input wire logic rateGenEnable, // rate generator enable
  output logic [7:0] rxData, // shift_buffer read data
  output logic masterSelect, // master select
  output logic txDir, // transmit direction
  output logic busBusyFlag, // bus busy
  output logic pending, // pending, 0 holds the clock low
  output logic lostFlag, // arbitration lost
  output logic addrMatch, // address matched
  output logic broadcastZeroFlag, // broadcast address seen
  output logic lastSampledBit, // data level at last clock rise
  output logic softInitDone, // soft init complete
  output logic transferIrq, // transfer_irq, one-cycle pulse
  output logic [1:0] funcSel, // interface function select
  output logic ackMode, // acknowledge mode
  output logic [2:0] bitCount, // bits per word
  output logic [6:0] ownSlaveId, // own slave id
  output logic freeFormatSelect // free format select
);
  localparam int CW = ibmc_pkg::CNT_W;
  localparam logic [CW-1:0] LOW_MAX = CW'(LOW_CYC - 1);
  localparam logic [CW-1:0] HIGH_MAX = CW'(HIGH_CYC - 1);

  function automatic logic addr_hit(input logic [7:0] rx, input logic [6:0] id);
    return (rx[7:1] == id) || (rx == ibmc_pkg::GEN_CALL);
  endfunction

  logic [1:0] syncOut;
  logic sclS, sdaS, sclRise, sclFall, startDet, stopDet;
  ibmc_pkg::ibmc_state_e state_reg, state_next;
  logic [CW-1:0] cnt_reg;
  logic [3:0] bitIdx_reg, dataLen, wordLen;
  logic [7:0] txShift_reg, rxShift_reg;
  logic afterStart_reg, firstWord_reg, addressed_reg, keyArmed_reg, softInit_reg;
  logic clr, busOn, startEv, stopEv, hit, roleTx, wordEnd, wordDone, loseNow;
  logic startReq, stopReq, swAccess, ackDrive, sdaNext, sclNext, countEn, rwBit;
  logic [3:0] cmd;

  ibmc_sync #(.WIDTH(2)) uSync (
    .clock(clock),
    .nrst(nrst),
    .din({sclIn, sdaIn}),
    .dout(syncOut)
  );

  ibmc_cond_det uDet (
    .clock(clock),
    .nrst(nrst),
    .scl(sclS),
    .sda(sdaS),
    .sclRise(sclRise),
    .sclFall(sclFall),
    .startDet(startDet),
    .stopDet(stopDet)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // decode

  assign sclS = syncOut[1];
  assign sdaS = syncOut[0];
  assign sclOut = 1'b0;
  assign sdaOut = 1'b0;
  assign clr = !nrst || softInit_reg;
  // the engine only runs with the bus function selected and the rate generator on
  assign busOn = (funcSel == ibmc_pkg::FUNC_BUS) && rateGenEnable;
  assign startEv = busOn && startDet;
  assign stopEv = busOn && stopDet;
  assign cmd = {masterIn, dirIn, busyIn, pendIn};
  assign rwBit = rxShift_reg[0];
  assign swAccess = bufWrite || bufRead;
  assign startReq = busOn && cr2Write && !busBusyFlag && cmd == ibmc_pkg::CMD_START
    && state_reg == ibmc_pkg::S_IDLE;
  assign stopReq = cr2Write && busBusyFlag && cmd == ibmc_pkg::CMD_STOP;
  assign hit = freeFormatSelect || addr_hit(rxShift_reg, ownSlaveId);
  // address word is always eight bits plus an acknowledge
  assign dataLen = (firstWord_reg || bitCount == ibmc_pkg::BC_RESET) ? ibmc_pkg::FULL_WORD
    : {1'b0, bitCount};
  assign wordLen = dataLen + {3'h0, ackMode || firstWord_reg};
  assign roleTx = firstWord_reg ? masterSelect : (txDir && (masterSelect || addressed_reg));
  assign wordEnd = busOn && sclFall && !afterStart_reg && bitIdx_reg == wordLen - 4'h1
    && (masterSelect || addressed_reg || firstWord_reg);
  // an unmatched address leaves a slave listening silently until the next start or stop
  assign wordDone = wordEnd && (masterSelect || !firstWord_reg || hit);
  // only bits this end drives high can be lost; the acknowledge slot is excluded
  assign loseNow = busOn && sclRise && masterSelect && roleTx && bitIdx_reg < dataLen
    && !sdaOe && !sdaS;
  assign ackDrive = firstWord_reg ? (!masterSelect && hit)
    : (!roleTx && ackMode && (masterSelect || addressed_reg));

  always_comb begin
    case (state_reg)
      ibmc_pkg::S_START, ibmc_pkg::S_STOPA, ibmc_pkg::S_STOPB: sdaNext = 1'b1;
      ibmc_pkg::S_IDLE, ibmc_pkg::S_STOPC: sdaNext = 1'b0;
      default: sdaNext = (bitIdx_reg < dataLen) ? (roleTx && !txShift_reg[7]) : ackDrive;
    endcase
  end

  always_comb begin
    case (state_reg)
      ibmc_pkg::S_LOW, ibmc_pkg::S_STOPA: sclNext = 1'b1;
      ibmc_pkg::S_HOLD: sclNext = 1'b1;
      default: sclNext = 1'b0;
    endcase
  end

  always_comb begin
    case (state_reg)
      ibmc_pkg::S_HIGH, ibmc_pkg::S_STOPB: countEn = sclS;
      ibmc_pkg::S_HOLD: countEn = pending;
      default: countEn = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sequencing

  always_comb begin
    state_next = state_reg;
    if (!busOn || stopEv) begin
      state_next = ibmc_pkg::S_IDLE;
    end else if (loseNow) begin
      state_next = ibmc_pkg::S_SLV;
    end else if (wordDone) begin
      state_next = ibmc_pkg::S_HOLD;
    end else begin
      case (state_reg)
        ibmc_pkg::S_IDLE: begin
          if (startReq) begin
            state_next = ibmc_pkg::S_START;
          end else if (startEv) begin
            state_next = ibmc_pkg::S_SLV;
          end
        end
        ibmc_pkg::S_START: begin
          if (cnt_reg == HIGH_MAX) begin
            state_next = ibmc_pkg::S_LOW;
          end
        end
        ibmc_pkg::S_LOW: begin
          if (cnt_reg == LOW_MAX) begin
            state_next = ibmc_pkg::S_HIGH;
          end
        end
        ibmc_pkg::S_HIGH: begin
          // another master pulling low early restarts our low phase
          if (sclFall || (sclS && cnt_reg == HIGH_MAX)) begin
            state_next = ibmc_pkg::S_LOW;
          end
        end
        ibmc_pkg::S_HOLD: begin
          if (stopReq && masterSelect) begin
            state_next = ibmc_pkg::S_STOPA;
          end else if (pending && cnt_reg == LOW_MAX) begin
            state_next = masterSelect ? ibmc_pkg::S_HIGH : ibmc_pkg::S_SLV;
          end
        end
        ibmc_pkg::S_STOPA: begin
          if (cnt_reg == LOW_MAX) begin
            state_next = ibmc_pkg::S_STOPB;
          end
        end
        ibmc_pkg::S_STOPB: begin
          if (sclS && cnt_reg == HIGH_MAX) begin
            state_next = ibmc_pkg::S_STOPC;
          end
        end
        default: state_next = state_reg;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (clr) begin
      state_reg <= ibmc_pkg::S_IDLE;
      cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      if (state_next != state_reg || !countEn) begin
        cnt_reg <= '0;
      end else begin
        cnt_reg <= cnt_reg + CW'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // bit tracking

  always_ff @(posedge clock) begin
    if (clr) begin
      bitIdx_reg <= 4'h0;
      afterStart_reg <= 1'b0;
      firstWord_reg <= 1'b0;
      txShift_reg <= 8'hFF;
      rxShift_reg <= 8'hFF;
      rxData <= 8'h00;
      lastSampledBit <= 1'b1;
    end else begin
      if (startEv) begin
        bitIdx_reg <= 4'h0;
        afterStart_reg <= 1'b1;
        firstWord_reg <= 1'b1;
      end else if (busOn && sclFall && afterStart_reg) begin
        afterStart_reg <= 1'b0;
      end else if (wordEnd) begin
        bitIdx_reg <= 4'h0;
        firstWord_reg <= 1'b0;
        rxData <= rxShift_reg;
      end else if (busOn && sclFall && (masterSelect || addressed_reg || firstWord_reg)) begin
        bitIdx_reg <= bitIdx_reg + 4'h1;
        if (bitIdx_reg < dataLen) begin
          txShift_reg <= {txShift_reg[6:0], 1'b1};
        end
      end
      if (busOn && sclRise) begin
        lastSampledBit <= sdaS;
        if (bitIdx_reg < dataLen) begin
          rxShift_reg <= {rxShift_reg[6:0], sdaS};
        end
      end
      if (bufWrite) begin
        txShift_reg <= bufWrData;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // control and status flags; later assignments take priority

  always_ff @(posedge clock) begin
    if (clr) begin
      masterSelect <= 1'b0;
      txDir <= 1'b0;
      pending <= ibmc_pkg::PEND_RESET;
      busBusyFlag <= 1'b0;
      lostFlag <= 1'b0;
      addrMatch <= 1'b0;
      broadcastZeroFlag <= 1'b0;
      addressed_reg <= 1'b0;
      transferIrq <= 1'b0;
    end else begin
      transferIrq <= wordDone;
      if (cr2Write) begin
        masterSelect <= masterIn;
        txDir <= dirIn;
        lostFlag <= 1'b0;
        if (pendIn) begin
          pending <= 1'b1;
        end
      end
      if (swAccess) begin
        pending <= 1'b1;
        lostFlag <= 1'b0;
        addrMatch <= 1'b0;
      end
      if (startEv) begin
        busBusyFlag <= 1'b1;
        broadcastZeroFlag <= 1'b0;
        addressed_reg <= 1'b0;
      end
      if (wordDone) begin
        pending <= 1'b0;
        if (firstWord_reg && masterSelect && !lastSampledBit) begin
          txDir <= !rwBit;
        end else if (firstWord_reg && !masterSelect) begin
          addressed_reg <= 1'b1;
          addrMatch <= 1'b1;
          if (!freeFormatSelect) begin
            txDir <= rwBit;
            broadcastZeroFlag <= rxShift_reg == ibmc_pkg::GEN_CALL;
          end
        end
      end
      if (loseNow) begin
        lostFlag <= 1'b1;
        masterSelect <= 1'b0;
        txDir <= 1'b0;
      end
      if (stopEv) begin
        busBusyFlag <= 1'b0;
        masterSelect <= 1'b0;
        txDir <= 1'b0;
        broadcastZeroFlag <= 1'b0;
        addressed_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // configuration and soft init

  always_ff @(posedge clock) begin
    if (clr) begin
      ackMode <= 1'b0;
      bitCount <= ibmc_pkg::BC_RESET;
      ownSlaveId <= ibmc_pkg::OWN_ID_RESET;
      freeFormatSelect <= 1'b0;
    end else begin
      if (cr1Write) begin
        ackMode <= ackModeIn;
        bitCount <= bitCountIn;
      end
      if (idWrite) begin
        ownSlaveId <= ownIdIn;
        freeFormatSelect <= freeFmtIn;
      end
    end
  end

  // the function select survives a soft init so the pins stay assigned
  always_ff @(posedge clock) begin
    if (!nrst) begin
      keyArmed_reg <= 1'b0;
      softInit_reg <= 1'b0;
      softInitDone <= ibmc_pkg::SOFT_DONE_RESET;
      funcSel <= ibmc_pkg::FUNC_PORT;
    end else begin
      softInit_reg <= cr2Write && keyArmed_reg && keyIn == ibmc_pkg::KEY_SECOND;
      if (softInit_reg) begin
        softInitDone <= 1'b1;
      end else if (cr2Write && keyArmed_reg && keyIn == ibmc_pkg::KEY_SECOND) begin
        softInitDone <= 1'b0;
      end
      if (cr2Write) begin
        keyArmed_reg <= keyIn == ibmc_pkg::KEY_FIRST;
        funcSel <= funcSelIn;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pin drivers, registered so the pins never see decode glitches

  always_ff @(posedge clock) begin
    if (clr) begin
      sclOe <= 1'b0;
      sdaOe <= 1'b0;
    end else begin
      sclOe <= busOn && sclNext && !(state_reg == ibmc_pkg::S_HOLD && pending
        && cnt_reg == LOW_MAX);
      sdaOe <= busOn && sdaNext;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence s_pend_rise;
    state_reg == ibmc_pkg::S_HOLD && $rose(pending) && !softInit_reg;
  endsequence

  sequence s_low_kept;
    sclOe [*8];
  endsequence

  a_start_busy: assert property (startEv && !stopEv && !softInit_reg |=> busBusyFlag)
    else $error("busy not set after start");
  a_stop_frees: assert property (stopEv |=> !busBusyFlag && !masterSelect && !txDir)
    else $error("stop left busy, master or direction set");
  a_word_pend: assert property (wordDone && !softInit_reg |=> !pending && transferIrq)
    else $error("word end did not clear pending and interrupt");
  a_hold_scl: assert property (state_reg == ibmc_pkg::S_HOLD && !pending && busOn
    && !softInit_reg |=> sclOe)
    else $error("clock not held low while pending is 0");
  a_rel_tlow: assert property (s_pend_rise |=> s_low_kept ##[1:1000] !sclOe)
    else $error("clock released too early or never");
  a_lose_slave: assert property ($rose(lostFlag) |-> !masterSelect && !txDir)
    else $error("loss did not make slave receiver");
  a_lose_sda: assert property ($rose(lostFlag) && !softInit_reg |=> !sdaOe)
    else $error("data line still driven after loss");
  a_access_clr: assert property (swAccess && !loseNow && !wordDone && !softInit_reg
    |=> pending && !lostFlag && !addrMatch)
    else $error("buffer access did not update flags");
  a_lrb_rise: assert property (busOn && sclRise && !softInit_reg
    |=> lastSampledBit == $past(sdaS))
    else $error("last bit not captured at clock rise");
  a_key_pair: assert property (keyArmed_reg && cr2Write && keyIn == ibmc_pkg::KEY_SECOND
    |=> !softInitDone ##1 softInitDone && !busBusyFlag && pending)
    else $error("soft init sequence wrong");
  a_gc_flag: assert property ((startEv || stopEv) && !softInit_reg
    |=> !broadcastZeroFlag)
    else $error("broadcast flag kept over start or stop");
  a_start_gen: assert property (startReq && !stopEv
    |=> state_reg == ibmc_pkg::S_START ##1 sdaOe)
    else $error("start request did not drive start");
  a_slave_dir: assert property (wordDone && firstWord_reg && !masterSelect
    && !freeFormatSelect && !softInit_reg |=> txDir == $past(rwBit))
    else $error("slave direction not taken from address");
  a_master_dir: assert property (wordDone && firstWord_reg && masterSelect
    && !lastSampledBit && !softInit_reg |=> txDir != $past(rwBit))
    else $error("master direction not inverted after ack");
endmodule
`default_nettype wire

// ---- sim/ibmc_bus_partner.sv ----
// open-drain bus partner model, master or addressed slave, standing on the far side of the controller
`timescale 1ns/100ps
`default_nettype none
module ibmc_bus_partner (
  input wire logic sclBus, // bus clock level
  input wire logic sdaBus, // bus data level
  output logic sclOe, // high pulls clock low
  output logic sdaOe // high pulls data low
);
  initial begin
    sclOe = 1'b0;
    sdaOe = 1'b0;
  end
  // let go of the clock and honour stretching, bounded so a stuck line cannot hang us
  task automatic relScl();
    sclOe = 1'b0;
    for (int n = 0; n < 3000 && sclBus !== 1'b1; n++) #10;
    #62.5;
  endtask
  task automatic startCond();
    sdaOe = 1'b1;
    #62.5;
    sclOe = 1'b1;
  endtask
  // data only moves in mid low phase so it never looks like a start or stop
  task automatic sendByte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #31.25;
      sdaOe = ~b[i];
      #31.25;
      relScl();
      sclOe = 1'b1;
    end
    #31.25;
    sdaOe = 1'b0;
    #31.25;
    relScl();
    ack = sdaBus;
    sclOe = 1'b1;
  endtask
  task automatic stopCond();
    #31.25;
    sdaOe = 1'b1;
    #31.25;
    relScl();
    sdaOe = 1'b0;
    #62.5;
  endtask
  task automatic jam(input logic on);
    sdaOe = on;
  endtask
  // addressed slave: acknowledge after the given number of clock falls, free data at the next
  task automatic ackAfter(input int falls);
    repeat (falls) @(negedge sclBus);
    #20;
    sdaOe = 1'b1;
    @(negedge sclBus);
    #20;
    sdaOe = 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- sim/ibmc_ctrl_test.sv ----
// self-checking bench for the two-wire bus-mode controller
`timescale 1ns/100ps
`default_nettype none
module ibmc_ctrl_test;
  logic clock = 1'b0, nrst = 1'b0, cr1Write = 1'b0, ackModeIn = 1'b0, cr2Write = 1'b0;
  logic masterIn = 1'b0, dirIn = 1'b0, busyIn = 1'b0, pendIn = 1'b0, idWrite = 1'b0;
  logic freeFmtIn = 1'b0, bufWrite = 1'b0, bufRead = 1'b0, rateGenEnable = 1'b1;
  logic [2:0] bitCountIn = 3'h0;
  logic [1:0] keyIn = 2'h0, funcSelIn = 2'h0;
  logic [6:0] ownIdIn = 7'h00;
  logic [7:0] bufWrData = 8'h00;
  logic sclOe, sdaOe, masterSelect, txDir, busBusyFlag, pending, lostFlag, addrMatch;
  logic broadcastZeroFlag, lastSampledBit, softInitDone, transferIrq, ackMode, freeFormatSelect;
  logic [7:0] rxData;
  logic [1:0] funcSel;
  logic [2:0] bitCount;
  logic [6:0] ownSlaveId;
  logic pSclOe, pSdaOe, ack;
  int numErrors = 0, samplesChecked = 0, irqCount = 0;
  // pull-ups on both lines: low while any party pulls
  wire sclBus = ~(sclOe | pSclOe);
  wire sdaBus = ~(sdaOe | pSdaOe);
  always #5 clock = ~clock;
  always @(posedge clock) if (transferIrq === 1'b1) irqCount <= irqCount + 1;
  ibmc_ctrl #(.LOW_CYC(10), .HIGH_CYC(10)) i_ibmc_ctrl (
    .clock, .nrst, .sclIn(sclBus), .sclOut(), .sclOe, .sdaIn(sdaBus), .sdaOut(), .sdaOe,
    .cr1Write, .ackModeIn, .bitCountIn, .cr2Write, .masterIn, .dirIn, .busyIn, .pendIn,
    .keyIn, .funcSelIn, .idWrite, .ownIdIn, .freeFmtIn, .bufWrite, .bufWrData, .bufRead,
    .rateGenEnable, .rxData, .masterSelect, .txDir, .busBusyFlag, .pending, .lostFlag,
    .addrMatch, .broadcastZeroFlag, .lastSampledBit, .softInitDone, .transferIrq, .funcSel,
    .ackMode, .bitCount, .ownSlaveId, .freeFormatSelect);
  ibmc_bus_partner i_ibmc_bus_partner (.sclBus, .sdaBus, .sclOe(pSclOe), .sdaOe(pSdaOe));
  //////////////////////////////////////////////////
  task automatic chkVal(input logic [7:0] got, input logic [7:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      numErrors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkBit(input logic got, input logic exp);
    chkVal({7'h00, got}, {7'h00, exp});
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samplesChecked, numErrors);
    if (numErrors == 0 && samplesChecked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // outputs answer one edge after the strobe; look a little after the next edge
  task automatic strobeEnd();
    @(posedge clock);
    {cr1Write, cr2Write, idWrite, bufWrite, bufRead} <= 5'h00;
    @(posedge clock);
    #1;
  endtask
  task automatic cr2(input logic [3:0] mtbp, input logic [1:0] key);
    @(posedge clock);
    {masterIn, dirIn, busyIn, pendIn} <= mtbp;
    keyIn <= key;
    funcSelIn <= 2'h2;
    cr2Write <= 1'b1;
    strobeEnd();
  endtask
  task automatic idw(input logic [6:0] id, input logic ff);
    @(posedge clock);
    ownIdIn <= id;
    freeFmtIn <= ff;
    idWrite <= 1'b1;
    strobeEnd();
  endtask
  task automatic bufAccess(input logic wr, input logic [7:0] d);
    @(posedge clock);
    bufWrData <= d;
    bufWrite <= wr;
    bufRead <= ~wr;
    strobeEnd();
  endtask
  task automatic waitHigh(ref logic f);
    for (int n = 0; n < 5000 && f !== 1'b1; n++) #10;
    @(posedge clock);
    #1;
  endtask
  task automatic slaveAddr(input logic [7:0] a);
    i_ibmc_bus_partner.startCond();
    i_ibmc_bus_partner.sendByte(a, ack);
    #200;
    @(posedge clock);
    #1;
  endtask
  task automatic busStop();
    i_ibmc_bus_partner.stopCond();
    @(posedge clock);
    #1;
  endtask
  initial begin
    #400000;
    numErrors++;
    tally_and_finish();
  end
  initial begin
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    #1;
    chkBit(pending, 1'b1);
    chkBit(softInitDone, 1'b1);
    @(posedge clock);
    ackModeIn <= 1'b1;
    cr1Write <= 1'b1;
    strobeEnd();
    cr2(4'h5, 2'h0);
    idw(7'h2A, 1'b0);
    $display("test setup done");
    slaveAddr(8'h54);
    chkBit(ack, 1'b0);
    chkBit(lastSampledBit, 1'b0);
    chkBit(busBusyFlag, 1'b1);
    chkBit(txDir, 1'b0);
    chkBit(addrMatch, 1'b1);
    chkBit(pending, 1'b0);
    chkVal(irqCount[7:0], 8'h01);
    cr2(4'h0, 2'h0);
    chkBit(pending, 1'b0);
    bufAccess(1'b0, 8'h00);
    chkBit(pending, 1'b1);
    chkBit(addrMatch, 1'b0);
    busStop();
    chkBit(busBusyFlag, 1'b0);
    $display("test own address done");
    slaveAddr(8'h00);
    chkBit(broadcastZeroFlag, 1'b1);
    chkBit(addrMatch, 1'b1);
    bufAccess(1'b0, 8'h00);
    busStop();
    chkBit(broadcastZeroFlag, 1'b0);
    slaveAddr(8'h20);
    chkBit(ack, 1'b1);
    chkBit(pending, 1'b1);
    chkVal(irqCount[7:0], 8'h02);
    busStop();
    $display("test broadcast and foreign address done");
    idw(7'h2A, 1'b1);
    slaveAddr(8'h20);
    chkBit(addrMatch, 1'b1);
    chkBit(pending, 1'b0);
    bufAccess(1'b0, 8'h00);
    busStop();
    idw(7'h2A, 1'b0);
    $display("test free format done");
    bufAccess(1'b1, 8'hA1);
    cr2(4'hF, 2'h0);
    // start fall plus eight address falls, then the acknowledge slot
    i_ibmc_bus_partner.ackAfter(9);
    #200;
    @(posedge clock);
    #1;
    chkBit(lastSampledBit, 1'b0);
    chkBit(txDir, 1'b0);
    chkBit(pending, 1'b0);
    chkVal(irqCount[7:0], 8'h04);
    cr2(4'hD, 2'h0);
    for (int n = 0; n < 500 && busBusyFlag !== 1'b0; n++) #10;
    chkBit(busBusyFlag, 1'b0);
    chkBit(masterSelect, 1'b0);
    chkBit(txDir, 1'b0);
    $display("test master done");
    bufAccess(1'b1, 8'hA0);
    cr2(4'hF, 2'h0);
    waitHigh(busBusyFlag);
    chkBit(masterSelect, 1'b1);
    i_ibmc_bus_partner.jam(1'b1);
    waitHigh(lostFlag);
    chkBit(lostFlag, 1'b1);
    chkBit(masterSelect, 1'b0);
    chkBit(txDir, 1'b0);
    #500;
    i_ibmc_bus_partner.jam(1'b0);
    #200;
    chkBit(busBusyFlag, 1'b0);
    cr2(4'h1, 2'h0);
    chkBit(lostFlag, 1'b0);
    $display("test arbitration done");
    cr2(4'h1, 2'h2);
    // the done flag is low for one cycle only, so look right after the taking edge
    @(posedge clock);
    keyIn <= 2'h1;
    cr2Write <= 1'b1;
    @(posedge clock);
    cr2Write <= 1'b0;
    #1;
    chkBit(softInitDone, 1'b0);
    @(posedge clock);
    #1;
    chkBit(softInitDone, 1'b1);
    chkBit(pending, 1'b1);
    chkVal({1'b0, ownSlaveId}, 8'h00);
    chkVal({6'h00, funcSel}, 8'h02);
    $display("test soft init done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
